// ===== bench/mmc_host.sv
// Host-side two-wire master model
`include "mmc_regs.vh"
module mmc_host (
  // Driven levels, 1 releases the line
  output logic scl_drv,
  output logic sda_drv,
  // Resolved line levels
  input wire scl_line,
  input wire sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime Q = 31.25ns;
  event rd_done;
  logic [8:0] rd_result;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // Both lines only ever pulled low or released
  task automatic bits(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_drv = d[i];
      #Q scl_drv = 1'b1;
      #Q r[i] = sda_line;
      #Q scl_drv = 1'b0;
      #Q;
    end
  endtask
  task automatic start;
    sda_drv = 1'b1;
    #Q scl_drv = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl_drv = 1'b0;
  endtask
  // Falling clock edge after stop starts the write or read effects
  task automatic stop(input logic commit);
    sda_drv = 1'b0;
    #Q scl_drv = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
    if (commit) begin
      #Q scl_drv = 1'b0;
      #Q scl_drv = 1'b1;
    end
  endtask
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, input logic commit);
    logic [8:0] r;
    start;
    bits({`MMC_DEV_ADDR, 2'b01}, r);
    bits({ptr, 1'b1}, r);
    bits({d, 1'b1}, r);
    stop(commit);
  endtask
  task automatic read_reg(input logic [7:0] ptr);
    logic [8:0] r;
    start;
    bits({`MMC_DEV_ADDR, 2'b01}, r);
    rd_result = 9'h000;
    if (r[0] === 1'b0) begin
      bits({ptr, 1'b1}, r);
      start;
      bits({`MMC_DEV_ADDR, 2'b11}, r);
      bits(9'h1ff, r);
      rd_result = {1'b1, r[8:1]};
    end
    stop(1'b1);
    -> rd_done;
  endtask
endmodule

// ===== bench/mmc_properties.sv
// Port checker for the management control block
module mmc_properties #(
  parameter [31:0] INIT_CYC = 32'h32,
  parameter [31:0] PDOWN_EXIT_CYC = 32'h32
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Host pins
  input wire module_select_n,
  input wire module_reset_n,
  input wire low_power_request,
  // Two-wire bus
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  // Status pins and state
  input wire module_present_n,
  input wire interrupt_out_n,
  input wire [7:0] flag_cond,
  input wire low_power_active,
  input wire fully_functional
);
  localparam [31:0] LIMIT = (INIT_CYC > PDOWN_EXIT_CYC ? INIT_CYC : PDOWN_EXIT_CYC) + 32'h8;
  reg [9:0] low_reg;
  reg [31:0] wait_reg;
  // Reset pin low time and time spent waiting to become functional
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      low_reg <= 10'h000;
      wait_reg <= 32'h0;
    end else begin
      low_reg <= module_reset_n ? 10'h000 : low_reg + {9'h000, low_reg != 10'h3ff};
      wait_reg <= (fully_functional | low_power_active | !module_reset_n) ? 32'h0 :
        wait_reg + 32'h1;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  a_present_low: assert property (!module_present_n)
    else $error("present pin high");
  a_no_stretch: assert property (!scl_oe)
    else $error("clock line driven");
  a_sda_open_drain: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_deselect_quiet: assert property (module_select_n [*4] |=> !sda_oe)
    else $error("bus answered while deselected");
  a_lp_pin: assert property (low_power_request [*4] |=> low_power_active)
    else $error("low power not entered");
  a_ready_int: assert property ($rose(fully_functional) |-> ##[0:3] !interrupt_out_n)
    else $error("no interrupt when ready");
  a_reinit_start: assert property ($rose(module_reset_n) && low_reg > 10'h208 |->
    ##[1:8] !fully_functional) else $error("long reset pulse ignored");
  a_ready_bound: assert property (wait_reg <= LIMIT)
    else $error("ready wait too long");
  c_ready: cover property ($rose(fully_functional));
  c_ack: cover property ($rose(sda_oe));
  c_low_power: cover property ($rose(low_power_active));
endmodule
bind mmc_top mmc_properties #(.INIT_CYC(INIT_CYC), .PDOWN_EXIT_CYC(PDOWN_EXIT_CYC)) u_props (
  .clk(clk), .reset(reset), .module_select_n(module_select_n), .module_reset_n(module_reset_n),
  .low_power_request(low_power_request), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .module_present_n(module_present_n),
  .interrupt_out_n(interrupt_out_n), .flag_cond(flag_cond),
  .low_power_active(low_power_active), .fully_functional(fully_functional));

// ===== bench/testbench.sv
// Self-checking bench for the management control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
  logic clk = 1'b0, reset = 1'b1, module_select_n = 1'b0, module_reset_n = 1'b1;
  logic low_power_request = 1'b0;
  logic [7:0] flag_cond = 8'h00;
  logic [31:0] rnd = 32'h0c9e;
  logic [8:0] exp_q[$];
  int fails = 0, check_count = 0;
  wire scl_out, scl_oe, sda_out, sda_oe, module_present_n, interrupt_out_n;
  wire low_power_active, fully_functional, scl_drv, sda_drv, scl_in, sda_in;
  assign scl_in = scl_drv & ~(scl_oe & ~scl_out);
  assign sda_in = sda_drv & ~(sda_oe & ~sda_out);
  always #2ns clk = ~clk;
  mmc_top #(.INIT_CYC(32'h32), .PDOWN_EXIT_CYC(32'h28)) i_dut (.clk(clk), .reset(reset),
    .module_select_n(module_select_n), .module_reset_n(module_reset_n),
    .low_power_request(low_power_request), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .module_present_n(module_present_n), .interrupt_out_n(interrupt_out_n),
    .flag_cond(flag_cond), .low_power_active(low_power_active),
    .fully_functional(fully_functional));
  mmc_host i_host (.scl_drv(scl_drv), .sda_drv(sda_drv), .scl_line(scl_in), .sda_line(sda_in));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic close_out;
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [8:0] e);
    exp_q.push_back(e);
    i_host.read_reg(ptr);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_ff;
    int i;
    for (i = 0; i < 300 && fully_functional !== 1'b1; i++) @(negedge clk);
    if (i == 300) begin
      $display("unexpected at %0t: ready wait ran out", $time);
      fails++;
      close_out;
    end
  endtask
  initial forever begin
    logic [8:0] e;
    @(i_host.rd_done);
    e = exp_q.pop_front();
    `CHK(i_host.rd_result, e)
  end
  initial begin
    #200us;
    $display("unexpected at %0t: run timed out", $time);
    fails++;
    close_out;
  end
  initial begin
    logic [2:0] b;
    idle(6);
    reset = 1'b0;
    wait_ff;
    idle(4);
    `CHK(interrupt_out_n, 1'b0)
    `CHK(module_present_n, 1'b0)
    rd(8'h02, 9'h102);
    idle(10);
    `CHK(interrupt_out_n, 1'b1)
    rnd = xs(rnd);
    b = rnd[2:0];
    flag_cond[b] = 1'b1;
    idle(6);
    `CHK(interrupt_out_n, 1'b0)
    i_host.write_reg(8'h64, 8'hff, 1'b0);
    idle(10);
    `CHK(interrupt_out_n, 1'b0)
    i_host.stop(1'b1);
    idle(10);
    `CHK(interrupt_out_n, 1'b1)
    i_host.write_reg(8'h64, 8'h00, 1'b1);
    idle(10);
    `CHK(interrupt_out_n, 1'b0)
    rd(8'h03, {1'b1, 8'h01 << b});
    idle(10);
    `CHK(interrupt_out_n, 1'b1)
    flag_cond = 8'h00;
    for (int k = 0; k < 3; k++) begin
      rnd = xs(rnd);
      i_host.write_reg(8'h64, rnd[7:0], 1'b1);
      rd(8'h64, {1'b1, rnd[7:0]});
    end
    i_host.write_reg(8'h10, 8'h5a, 1'b1);
    rd(8'h10, 9'h100);
    i_host.write_reg(8'h5d, 8'h01, 1'b1);
    idle(10);
    `CHK({low_power_active, fully_functional}, 2'b10)
    rd(8'h5d, 9'h101);
    i_host.write_reg(8'h5d, 8'h00, 1'b1);
    idle(10);
    `CHK(fully_functional, 1'b0)
    wait_ff;
    rd(8'h02, 9'h102);
    low_power_request = 1'b1;
    idle(10);
    low_power_request = 1'b0;
    wait_ff;
    rd(8'h02, 9'h102);
    @(negedge clk) module_select_n = 1'b1;
    idle(10);
    rd(8'h02, 9'h000);
    @(negedge clk) module_select_n = 1'b0;
    idle(10);
    rd(8'h02, 9'h100);
    i_host.write_reg(8'h64, 8'h55, 1'b1);
    @(negedge clk) module_reset_n = 1'b0;
    idle(100);
    module_reset_n = 1'b1;
    idle(10);
    `CHK(fully_functional, 1'b1)
    module_reset_n = 1'b0;
    idle(600);
    module_reset_n = 1'b1;
    idle(10);
    `CHK(fully_functional, 1'b0)
    wait_ff;
    rd(8'h64, 9'h100);
    idle(4);
    close_out;
  end
endmodule

// ===== src/mmc_regs.vh
// Constants for the module management control block
`ifndef MMC_REGS_VH
`define MMC_REGS_VH
`define MMC_DEV_ADDR 7'h50
`define MMC_ADDR_STATUS 8'h02
`define MMC_ADDR_FLAGS 8'h03
`define MMC_ADDR_CTRL 8'h5d
`define MMC_ADDR_MASK 8'h64
`define MMC_STAT_DNR_BIT 0
`define MMC_STAT_INIT_BIT 1
`define MMC_CTRL_PDOWN_BIT 0
`define MMC_MASK_RST 8'h00
`define MMC_CTRL_RST 8'h00
`define MMC_CLK_MHZ 250
`define MMC_RESET_MIN_US 2
`define MMC_RESET_MIN_CYC (`MMC_RESET_MIN_US * `MMC_CLK_MHZ)
`define MMC_INIT_MS 2000
`define MMC_INIT_CYC (`MMC_INIT_MS * `MMC_CLK_MHZ * 1000)
`define MMC_PDOWN_EXIT_MS 300
`define MMC_PDOWN_EXIT_CYC (`MMC_PDOWN_EXIT_MS * `MMC_CLK_MHZ * 1000)
`define MMC_MASK_MS 100
`define MMC_SELECT_US 100
`define MMC_PDOWN_ENTER_MS 100
`define MMC_INT_RELEASE_US 500
`endif

// ===== src/mmc_sync.v
// Two flip-flop synchroniser for pin inputs
module mmc_sync #(
  parameter W = 5,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Asynchronous inputs and their synchronised copies
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ===== src/mmc_top.v
// Module management control: two-wire slave, select, reset, power and interrupt
// Overview of operation
// - Set mask bit inhibits interrupt within 100 ms
// - Cleared mask bit resumes interrupt within 100 ms
// - Respond on bus within 100 us of select
// - Stop responding within 100 us of deselect
// - Power-down bit set enters low power quickly
// - Power-down bit cleared, fully functional within 300 ms
// - Data-not-ready cleared asserts the interrupt output
// - Write effects start at falling clock after stop
// - Read clears start at falling clock after stop
// - Clock and data lines are shared open-drain
// - Clear-on-read releases interrupt within 500 us
// - Long reset low reinitialises within 2000 ms
`include "mmc_regs.vh"
module mmc_top #(
  parameter [31:0] INIT_CYC = `MMC_INIT_CYC,
  parameter [31:0] PDOWN_EXIT_CYC = `MMC_PDOWN_EXIT_CYC,
  parameter [6:0] DEV_ADDR = `MMC_DEV_ADDR
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Management pins from the host
  input wire module_select_n,
  input wire module_reset_n,
  input wire low_power_request,
  // Two-wire bus
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // Management pins to the host
  output reg module_present_n,
  output reg interrupt_out_n,
  // Internal conditions and module state
  input wire [7:0] flag_cond,
  output reg low_power_active,
  output reg fully_functional
);
  localparam [2:0] ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_AACK = 3'h2, ST_WR = 3'h3;
  localparam [2:0] ST_WACK = 3'h4, ST_RD = 3'h5, ST_RACK = 3'h6;
  localparam [31:0] RST_MIN = `MMC_RESET_MIN_CYC;
  wire [4:0] pins_s;
  wire scl_s = pins_s[0];
  wire sda_s = pins_s[1];
  wire sel_n_s = pins_s[2];
  wire rst_n_s = pins_s[3];
  wire lpm_s = pins_s[4];
  reg scl_d_reg, sda_d_reg, rst_n_d_reg, rst_armed_reg, rw_reg, first_byte_reg, master_ack_reg;
  reg post_stop_reg, cor_init_reg, dnr_reg, init_flag_reg, pwr_low_d_reg;
  reg [1:0] stage_wr_reg;
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [9:0] rst_low_cnt_reg;
  reg [31:0] ready_cnt_reg;
  reg [7:0] shift_reg, ptr_reg, mask_reg, ctrl_reg, stage_mask_reg, stage_ctrl_reg;
  reg [7:0] flags_reg, flag_d_reg, cor_flags_reg;
  mmc_sync #(.W(5), .RST_VAL(5'h0f)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({low_power_request, module_reset_n, module_select_n, sda_in, scl_in}),
    .q(pins_s)
  );
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire selected = ~sel_n_s;
  wire commit = post_stop_reg & scl_fall;
  wire reinit = rst_n_s & ~rst_n_d_reg & rst_armed_reg;
  wire pwr_low = ctrl_reg[`MMC_CTRL_PDOWN_BIT] | lpm_s;
  wire [7:0] flag_rise = flag_cond & ~flag_d_reg;
  wire [7:0] rd_byte = reg_read(ptr_reg);
  function [7:0] reg_read;
    input [7:0] a;
    begin
      if (a == `MMC_ADDR_STATUS) begin
        reg_read = {6'h00, init_flag_reg, dnr_reg};
      end else if (a == `MMC_ADDR_FLAGS) begin
        reg_read = flags_reg;
      end else if (a == `MMC_ADDR_CTRL) begin
        reg_read = ctrl_reg;
      end else if (a == `MMC_ADDR_MASK) begin
        reg_read = mask_reg;
      end else begin
        reg_read = 8'h00;
      end
    end
  endfunction
  // Reset pin filter and edge tracking
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      rst_n_d_reg <= 1'b1;
      rst_low_cnt_reg <= 10'h000;
      rst_armed_reg <= 1'b0;
      flag_d_reg <= 8'h00;
      pwr_low_d_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      rst_n_d_reg <= rst_n_s;
      flag_d_reg <= flag_cond;
      pwr_low_d_reg <= pwr_low;
      if (rst_n_s) begin
        rst_low_cnt_reg <= 10'h000;
        rst_armed_reg <= 1'b0;
      end else if ({22'h0, rst_low_cnt_reg} < RST_MIN) begin
        rst_low_cnt_reg <= rst_low_cnt_reg + 10'h001;
      end else begin
        rst_armed_reg <= 1'b1;
      end
    end
  end
  // Two-wire slave, staged writes and clear-on-read
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_byte_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      sda_oe <= 1'b0;
      stage_mask_reg <= `MMC_MASK_RST;
      stage_ctrl_reg <= `MMC_CTRL_RST;
      stage_wr_reg <= 2'h0;
      cor_flags_reg <= 8'h00;
      cor_init_reg <= 1'b0;
      post_stop_reg <= 1'b0;
    end else if (reinit) begin
      state_reg <= ST_IDLE;
      sda_oe <= 1'b0;
      stage_wr_reg <= 2'h0;
      cor_flags_reg <= 8'h00;
      cor_init_reg <= 1'b0;
      post_stop_reg <= 1'b0;
    end else begin
      if (commit) begin
        post_stop_reg <= 1'b0;
        stage_wr_reg <= 2'h0;
        cor_flags_reg <= 8'h00;
        cor_init_reg <= 1'b0;
      end else if (bus_stop) begin
        post_stop_reg <= 1'b1;
      end
      if (!selected || bus_stop) begin
        state_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state_reg == ST_ADDR || state_reg == ST_WR) begin
          shift_reg <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (state_reg == ST_RACK) begin
          master_ack_reg <= ~sda_s;
        end
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_reg <= shift_reg[0];
                state_reg <= ST_AACK;
                sda_oe <= 1'b1;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_AACK, ST_RACK: begin
            if (state_reg == ST_AACK ? rw_reg : master_ack_reg) begin
              shift_reg <= rd_byte;
              ptr_reg <= ptr_reg + 8'h01;
              bit_cnt_reg <= 4'h1;
              sda_oe <= ~rd_byte[7];
              state_reg <= ST_RD;
              if (ptr_reg == `MMC_ADDR_FLAGS) begin
                cor_flags_reg <= cor_flags_reg | flags_reg;
              end else if (ptr_reg == `MMC_ADDR_STATUS) begin
                cor_init_reg <= 1'b1;
              end
            end else if (state_reg == ST_AACK) begin
              first_byte_reg <= 1'b1;
              bit_cnt_reg <= 4'h0;
              sda_oe <= 1'b0;
              state_reg <= ST_WR;
            end else begin
              sda_oe <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
          ST_WR: begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe <= 1'b1;
              state_reg <= ST_WACK;
              if (first_byte_reg) begin
                ptr_reg <= shift_reg;
              end else begin
                ptr_reg <= ptr_reg + 8'h01;
                if (ptr_reg == `MMC_ADDR_MASK) begin
                  stage_mask_reg <= shift_reg;
                  stage_wr_reg[0] <= 1'b1;
                end else if (ptr_reg == `MMC_ADDR_CTRL) begin
                  stage_ctrl_reg <= shift_reg;
                  stage_wr_reg[1] <= 1'b1;
                end
              end
            end
          end
          ST_WACK: begin
            sda_oe <= 1'b0;
            first_byte_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_WR;
          end
          ST_RD: begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe <= 1'b0;
              state_reg <= ST_RACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe <= ~shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
  // Control, status, power and interrupt state
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_reg <= `MMC_MASK_RST;
      ctrl_reg <= `MMC_CTRL_RST;
      flags_reg <= 8'h00;
      dnr_reg <= 1'b1;
      init_flag_reg <= 1'b0;
      ready_cnt_reg <= INIT_CYC;
      low_power_active <= 1'b0;
      fully_functional <= 1'b0;
      interrupt_out_n <= 1'b1;
      module_present_n <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (reinit) begin
      mask_reg <= `MMC_MASK_RST;
      ctrl_reg <= `MMC_CTRL_RST;
      flags_reg <= 8'h00;
      dnr_reg <= 1'b1;
      init_flag_reg <= 1'b0;
      ready_cnt_reg <= INIT_CYC;
      fully_functional <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      module_present_n <= 1'b0;
      if (commit && stage_wr_reg[0]) begin
        mask_reg <= stage_mask_reg;
      end
      if (commit && stage_wr_reg[1]) begin
        ctrl_reg <= stage_ctrl_reg;
      end
      flags_reg <= (flags_reg & ~(commit ? cor_flags_reg : 8'h00)) | flag_rise;
      low_power_active <= pwr_low;
      if (pwr_low) begin
        dnr_reg <= 1'b1;
      end else if (pwr_low_d_reg) begin
        ready_cnt_reg <= PDOWN_EXIT_CYC;
      end else if (ready_cnt_reg != 32'h0) begin
        ready_cnt_reg <= ready_cnt_reg - 32'h1;
        if (ready_cnt_reg == 32'h1) begin
          dnr_reg <= 1'b0;
        end
      end
      if (!pwr_low && ready_cnt_reg == 32'h1) begin
        init_flag_reg <= 1'b1;
      end else if (commit && cor_init_reg) begin
        init_flag_reg <= 1'b0;
      end
      fully_functional <= ~dnr_reg;
      interrupt_out_n <= ~((|(flags_reg & ~mask_reg)) | init_flag_reg);
    end
  end
endmodule
